// [rtl/bcu_pkg.sv]
// Constants, types and decode table of the branch, compare and load unit.
// Assumes one 20 MHz bus clock and an AHB-Lite master doing word transfers.
// Notes on behaviour
// - Opcode 28 branches when half carry is zero; 3 cycles; flags kept.
// - Opcode 22 branches if C and Z clear; 23 if either set.
// - Opcode 2F branches when interrupt pin high; 2E when low.
// - Opcode 91 branches if N xor V; 93 also when Z set.
// - Opcode 2C branches when mask clear; 2D when mask set.
// - Odd opcodes 01-0F branch if direct bit is zero; carry gets bit; 5 cycles.
// - Even opcodes 00-0E branch if direct bit is one; carry gets bit; 5 cycles.
// - Opcode 10 plus twice n sets direct bit n; flags kept; 5 cycles.
// - Opcode AD pushes PC plus 2 low then high, SP down twice, adds offset.
// - Compare-branch tests A or X against operand, branches if equal, flags kept.
// - Opcode 98 clears carry, 9A clears mask; one cycle, nothing else.
// - Clear zeroes memory, A, X or H (8C); V=0, N=0, Z=1.
// - Compare subtracts operand from A for V, N, Z, C only; A1 is 2 cycles.
// - Complement gives FF minus operand; V=0, C=1, N and Z updated.
// - Opcodes 65 and 75 compare H:X with a 16-bit operand for V, N, Z, C.
// - Opcode 72 adjusts A to packed BCD; N, Z, C updated, V left.
// - Decrement-branch decrements A, X or memory, branches if nonzero, flags kept.
// - Opcode 52 divides H:A by X; quotient to A, remainder to H; Z, C.
// - Absolute call pushes return address low then high and jumps; BD 5 cycles.
// - Index load fills H:X high byte first; V=0, N and Z updated.
// - Shift right feeds zero into bit 7, bit 0 into carry, N=0.
// - Move copies a byte, V=0, N and Z updated; post-increment forms bump H:X.
// - Flag byte: V bit 7, H bit 4, I bit 3, N bit 2, Z bit 1, C bit 0.
package bcu_pkg;
  localparam logic [2:0]  IDX_INSTR = 3'h0, IDX_OPND = 3'h1, IDX_CORE = 3'h2;
  localparam logic [2:0]  IDX_PCSP = 3'h3, IDX_START = 3'h4, IDX_STAT = 3'h5;
  localparam logic [2:0]  IDX_ADDR = 3'h6, IDX_RET = 3'h7;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [15:0] RST_PC = 16'h0000, RST_SP = 16'h00FF;
  localparam logic [7:0]  RST_FLAGS = 8'h08;
  localparam logic [15:0] PUSH_BYTES = 16'h0002, HX_STEP = 16'h0001;
  localparam logic [7:0]  BCD_LO_FIX = 8'h06, BCD_HI_FIX = 8'h60, BCD_MAX = 8'h99;
  localparam logic [3:0]  BCD_DIGIT = 4'h9;
  localparam logic [7:0]  OP_HC_ZERO = 8'h28, OP_HC_ONE = 8'h29, OP_HIGHER = 8'h22;
  localparam logic [7:0]  OP_LOWSAME = 8'h23, OP_PIN_LOW = 8'h2E, OP_PIN_HIGH = 8'h2F;
  localparam logic [7:0]  OP_SLESS = 8'h91, OP_SLESSEQ = 8'h93, OP_MASK_ZERO = 8'h2C;
  localparam logic [7:0]  OP_MASK_ONE = 8'h2D, OP_RCALL = 8'hAD, OP_CPB_DIR = 8'h31;
  localparam logic [7:0]  OP_CPB_IMMA = 8'h41, OP_CPB_IMMX = 8'h51, OP_CPB_IX1P = 8'h61;
  localparam logic [7:0]  OP_CPB_IXP = 8'h71, OP_CARRY_OFF = 8'h98, OP_MASK_OFF = 8'h9A;
  localparam logic [7:0]  OP_ZERO_H = 8'h8C, OP_PAIR_IMM = 8'h65, OP_PAIR_DIR = 8'h75;
  localparam logic [7:0]  OP_DECADJ = 8'h72, OP_DIVIDE = 8'h52, OP_XLD_IMM = 8'h45;
  localparam logic [7:0]  OP_XLD_DIR = 8'h55, OP_XLD_EXT = 8'h32, OP_CPY_DD = 8'h4E;
  localparam logic [7:0]  OP_CPY_DX = 8'h5E, OP_CPY_ID = 8'h6E, OP_CPY_XD = 8'h7E;
  localparam logic [3:0]  COL_BTST = 4'h0, COL_DIRECT_BIT_FORCE_ONE = 4'h1, COL_INHA = 4'h4;
  localparam logic [3:0]  COL_INHX = 4'h5, COL_IX1 = 4'h6, COL_IX = 4'h7, COL_IMM = 4'hA;
  localparam logic [3:0]  COL_EXT = 4'hC, COL_IX2 = 4'hD, COL_IX1B = 4'hE, COL_IXB = 4'hF;
  localparam logic [3:0]  LO_COMPARE = 4'h1, LO_INVERT = 4'h3, LO_SHIFT = 4'h4;
  localparam logic [3:0]  LO_DECBR = 4'hB, LO_CALL = 4'hD, LO_ZERO = 4'hF;

  typedef struct packed {
    logic       v;
    logic [1:0] rsv;
    logic       h;
    logic       i;
    logic       n;
    logic       z;
    logic       c;
  } bcu_flags_s;

  typedef struct packed {
    logic       legal;
    logic [1:0] len;
    logic [3:0] cyc;
  } bcu_op_s;

  typedef enum {ST_IDLE, ST_RUN} bcu_state_e;

  // Instruction length in bytes and bus cycles per opcode.
  function automatic bcu_op_s bcu_decode(input logic [7:0] op);
    bcu_op_s r;
    case (op)
      8'h22, 8'h23, 8'h28, 8'h29, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h91, 8'h93, 8'hB1,
      8'hE1:                             r = '{1'b1, 2'd2, 4'd3};
      8'h71, 8'hAD, 8'hBD, 8'hED, 8'h3F, 8'h6F, 8'h33, 8'h63, 8'h34, 8'h64, 8'h5E,
      8'h75, 8'h7E:                      r = '{1'b1, 2'd2, 4'd5};
      8'h31, 8'h61, 8'h32, 8'h4E:        r = '{1'b1, 2'd3, 4'd5};
      8'h41, 8'h51, 8'hC1, 8'hD1, 8'h6E: r = '{1'b1, 2'd3, 4'd4};
      8'h3B, 8'h6B:                      r = '{1'b1, 2'd3, 4'd7};
      8'h4B, 8'h5B, 8'h55:               r = '{1'b1, 2'd2, 4'd4};
      8'h7B:                             r = '{1'b1, 2'd2, 4'd6};
      8'h98, 8'h9A, 8'h4F, 8'h5F, 8'h8C, 8'h43, 8'h53, 8'h72, 8'h44,
      8'h54:                             r = '{1'b1, 2'd1, 4'd1};
      8'h7F, 8'h73, 8'h74:               r = '{1'b1, 2'd1, 4'd4};
      8'h52:                             r = '{1'b1, 2'd1, 4'd6};
      8'hFD:                             r = '{1'b1, 2'd1, 4'd5};
      8'hA1:                             r = '{1'b1, 2'd2, 4'd2};
      8'hF1:                             r = '{1'b1, 2'd1, 4'd3};
      8'h65, 8'h45:                      r = '{1'b1, 2'd3, 4'd3};
      8'hCD, 8'hDD:                      r = '{1'b1, 2'd3, 4'd6};
      default: begin
        if (op[7:4] == COL_BTST)
          r = '{1'b1, 2'd3, 4'd5};
        else if (op[7:4] == COL_DIRECT_BIT_FORCE_ONE && !op[0])
          r = '{1'b1, 2'd2, 4'd5};
        else
          r = '{1'b0, 2'd1, 4'd1};
      end
    endcase
    return r;
  endfunction
endpackage

// [rtl/bcu_core.sv]
// Execution unit for the branch, compare, clear, load and move opcodes.
// Assumes a single AHB-Lite master; software stages the opcode, its operand
// bytes and any memory bytes, then starts one instruction at a time.
`timescale 1ns/100ps
module bcu_core
  import bcu_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        irq_pin
);

  logic [7:0]  op, o1, o2, mb, mb2, a, x, h;
  bcu_flags_s  fl;
  logic [15:0] pc, sp;
  bcu_state_e  state;
  logic [3:0]  cnt;
  logic        taken, illegal, st_we, pu_we;
  logic [7:0]  st_data;
  logic [15:0] st_addr, ret;
  logic        rd_ph, wr_ph, dp_map;
  logic [2:0]  dp_idx;
  logic [31:0] rd_val;
  logic        wr_ok, start;
  bcu_op_s     dec;
  logic [15:0] hx, ea, seq, tgt, opd16, n_pc, n_sp, s_addr;
  logic [7:0]  rel, opd, res, n_a, n_x, n_h, s_data;
  logic [8:0]  d9;
  logic [16:0] d17;
  logic [15:0] quo, rem;
  bcu_flags_s  n_f;
  logic        br, wb, s_we, p_we, lo_fix, hi_fix;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero-wait writes, one wait state on reads.

  assign hresp     = 1'b0;
  assign hreadyout = ~rd_ph;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph  <= 1'b0;
      wr_ph  <= 1'b0;
      dp_idx <= IDX_INSTR;
      dp_map <= 1'b0;
    end else if (hready) begin
      rd_ph  <= hsel & htrans[1] & ~hwrite;
      wr_ph  <= hsel & htrans[1] & hwrite & (hsize == HSIZE_WORD);
      dp_idx <= haddr[4:2];
      dp_map <= (haddr[31:5] == 27'h0) & (haddr[1:0] == 2'b00);
    end else begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
    end
  end

  always_comb begin
    case (dp_idx)
      IDX_INSTR: rd_val = {8'h00, o2, o1, op};
      IDX_OPND:  rd_val = {16'h0000, mb2, mb};
      IDX_CORE:  rd_val = {fl, h, x, a};
      IDX_PCSP:  rd_val = {sp, pc};
      IDX_STAT:  rd_val = {8'h00, st_data, 4'h0, cnt, 3'b000, pu_we, st_we, illegal,
                           taken, state == ST_RUN};
      IDX_ADDR:  rd_val = {st_addr, ea};
      IDX_RET:   rd_val = {16'h0000, ret};
      default:   rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_ph)
      hrdata <= dp_map ? rd_val : 32'h0000_0000;
  end

  assign wr_ok = wr_ph & dp_map & (state == ST_IDLE);
  assign start = wr_ok & (dp_idx == IDX_START) & hwdata[0];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution, evaluated in full from the staged bytes.

  always_comb begin
    dec = bcu_decode(op);
    hx  = {h, x};
    seq = pc + {14'h0000, dec.len};
    rel = (dec.len == 2'd3) ? o2 : o1;
    tgt = seq + {{8{rel[7]}}, rel};
    case (op[7:4])
      COL_IX1, COL_IX1B: ea = hx + {8'h00, o1};
      COL_IX, COL_IXB:   ea = hx;
      COL_EXT:           ea = {o1, o2};
      COL_IX2:           ea = hx + {o1, o2};
      default:           ea = (op == OP_XLD_EXT) ? {o1, o2} : {8'h00, o1};
    endcase
    n_a = a;
    n_x = x;
    n_h = h;
    n_f = fl;
    n_pc = seq;
    n_sp = sp;
    br = 1'b0;
    wb = 1'b0;
    s_we = 1'b0;
    p_we = 1'b0;
    s_addr = ea;
    s_data = 8'h00;
    res = 8'h00;
    opd = (op[7:4] == COL_IMM) ? o1 : mb;
    opd16 = (op == OP_PAIR_IMM || op == OP_XLD_IMM) ? {o1, o2} : {mb, mb2};
    d9 = {1'b0, a} - {1'b0, opd};
    d17 = {1'b0, hx} - {1'b0, opd16};
    quo = {h, a} / {8'h00, x};
    rem = {h, a} % {8'h00, x};
    lo_fix = fl.h | (a[3:0] > BCD_DIGIT);
    hi_fix = fl.c | (a > BCD_MAX);
    case (op)
      OP_HC_ZERO:   br = ~fl.h;
      OP_HC_ONE:    br = fl.h;
      OP_HIGHER:    br = ~(fl.c | fl.z);
      OP_LOWSAME:   br = fl.c | fl.z;
      OP_PIN_HIGH:  br = irq_pin;
      OP_PIN_LOW:   br = ~irq_pin;
      OP_SLESS:     br = fl.n ^ fl.v;
      OP_SLESSEQ:   br = fl.z | (fl.n ^ fl.v);
      OP_MASK_ZERO: br = ~fl.i;
      OP_MASK_ONE:  br = fl.i;
      OP_RCALL: begin
        p_we = 1'b1;
        n_sp = sp - PUSH_BYTES;
        br   = 1'b1;
      end
      OP_CPB_DIR:   br = (a == mb);
      OP_CPB_IMMA:  br = (a == o1);
      OP_CPB_IMMX:  br = (x == o1);
      OP_CPB_IX1P, OP_CPB_IXP: begin
        br = (a == mb);
        {n_h, n_x} = hx + HX_STEP;
      end
      OP_CARRY_OFF: n_f.c = 1'b0;
      OP_MASK_OFF:  n_f.i = 1'b0;
      OP_ZERO_H: begin
        n_h = 8'h00;
        n_f.v = 1'b0;
        n_f.n = 1'b0;
        n_f.z = 1'b1;
      end
      OP_PAIR_IMM, OP_PAIR_DIR: begin
        n_f.c = d17[16];
        n_f.n = d17[15];
        n_f.z = (d17[15:0] == 16'h0000);
        n_f.v = (h[7] & ~opd16[15] & ~d17[15]) | (~h[7] & opd16[15] & d17[15]);
      end
      OP_DECADJ: begin
        n_a = a + (lo_fix ? BCD_LO_FIX : 8'h00) + (hi_fix ? BCD_HI_FIX : 8'h00);
        n_f.n = n_a[7];
        n_f.z = (n_a == 8'h00);
        n_f.c = hi_fix;
      end
      OP_DIVIDE: begin
        if (h >= x) begin
          n_f.c = 1'b1;
        end else begin
          n_a = quo[7:0];
          n_h = rem[7:0];
          n_f.c = 1'b0;
          n_f.z = (quo[7:0] == 8'h00);
        end
      end
      OP_XLD_IMM, OP_XLD_DIR, OP_XLD_EXT: begin
        {n_h, n_x} = opd16;
        n_f.v = 1'b0;
        n_f.n = opd16[15];
        n_f.z = (opd16 == 16'h0000);
      end
      OP_CPY_DD, OP_CPY_DX, OP_CPY_ID, OP_CPY_XD: begin
        s_we = 1'b1;
        s_data = (op == OP_CPY_ID) ? o1 : mb;
        s_addr = (op == OP_CPY_DX) ? hx : {8'h00, (op == OP_CPY_XD) ? o1 : o2};
        if (op == OP_CPY_DX || op == OP_CPY_XD)
          {n_h, n_x} = hx + HX_STEP;
        n_f.v = 1'b0;
        n_f.n = s_data[7];
        n_f.z = (s_data == 8'h00);
      end
      default: begin
        if (op[7:4] == COL_BTST) begin
          n_f.c = mb[op[3:1]];
          br = op[0] ? ~mb[op[3:1]] : mb[op[3:1]];
        end else if (op[7:4] == COL_DIRECT_BIT_FORCE_ONE) begin
          s_we = 1'b1;
          s_addr = {8'h00, o1};
          s_data = mb | (8'h01 << op[3:1]);
        end else begin
          if (op[7:4] == COL_INHA)
            opd = a;
          else if (op[7:4] == COL_INHX)
            opd = x;
          case (op[3:0])
            LO_COMPARE: begin
              n_f.c = d9[8];
              n_f.n = d9[7];
              n_f.z = (d9[7:0] == 8'h00);
              n_f.v = (a[7] & ~opd[7] & ~d9[7]) | (~a[7] & opd[7] & d9[7]);
            end
            LO_INVERT: begin
              res = ~opd;
              wb = 1'b1;
              n_f.v = 1'b0;
              n_f.c = 1'b1;
              n_f.n = res[7];
              n_f.z = (res == 8'h00);
            end
            LO_SHIFT: begin
              res = {1'b0, opd[7:1]};
              wb = 1'b1;
              n_f.c = opd[0];
              n_f.n = 1'b0;
              n_f.z = (res == 8'h00);
              n_f.v = opd[0];
            end
            LO_DECBR: begin
              res = opd - 8'h01;
              wb = 1'b1;
              br = (res != 8'h00);
            end
            LO_ZERO: begin
              res = 8'h00;
              wb = 1'b1;
              n_f.v = 1'b0;
              n_f.n = 1'b0;
              n_f.z = 1'b1;
            end
            LO_CALL: begin
              p_we = 1'b1;
              n_sp = sp - PUSH_BYTES;
              n_pc = ea;
            end
            default: ;
          endcase
        end
      end
    endcase
    if (wb) begin
      if (op[7:4] == COL_INHA)
        n_a = res;
      else if (op[7:4] == COL_INHX)
        n_x = res;
      else begin
        s_we = 1'b1;
        s_data = res;
      end
    end
    if (br)
      n_pc = tgt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staged instruction and operand bytes.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op  <= 8'h00;
      o1  <= 8'h00;
      o2  <= 8'h00;
      mb  <= 8'h00;
      mb2 <= 8'h00;
    end else if (wr_ok && dp_idx == IDX_INSTR) begin
      op <= hwdata[7:0];
      o1 <= hwdata[15:8];
      o2 <= hwdata[23:16];
    end else if (wr_ok && dp_idx == IDX_OPND) begin
      mb  <= hwdata[7:0];
      mb2 <= hwdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator, index pair and flag byte.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a  <= 8'h00;
      x  <= 8'h00;
      h  <= 8'h00;
      fl <= RST_FLAGS;
    end else if (start && dec.legal) begin
      a  <= n_a;
      x  <= n_x;
      h  <= n_h;
      fl <= n_f;
    end else if (wr_ok && dp_idx == IDX_CORE) begin
      a  <= hwdata[7:0];
      x  <= hwdata[15:8];
      h  <= hwdata[23:16];
      fl <= hwdata[31:24];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and stack pointer.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= RST_PC;
      sp <= RST_SP;
    end else if (start && dec.legal) begin
      pc <= n_pc;
      sp <= n_sp;
    end else if (wr_ok && dp_idx == IDX_PCSP) begin
      pc <= hwdata[15:0];
      sp <= hwdata[31:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outcome of the last instruction: store, push and branch reports.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken   <= 1'b0;
      illegal <= 1'b0;
      st_we   <= 1'b0;
      pu_we   <= 1'b0;
      st_data <= 8'h00;
      st_addr <= 16'h0000;
      ret     <= 16'h0000;
    end else if (start) begin
      taken   <= br & dec.legal;
      illegal <= ~dec.legal;
      st_we   <= s_we & dec.legal;
      pu_we   <= p_we & dec.legal;
      st_data <= s_data;
      st_addr <= p_we ? sp : s_addr;
      ret     <= seq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy for exactly the opcode's cycle count, taken or not.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_RUN;
            cnt   <= dec.cyc;
          end
        end
        ST_RUN: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // bcu_core

// [tb/bcu_pin_model.sv]
// Model of the external interrupt pin source beside the core.
// Assumes the bench asks for a level; the pin moves just after a clock edge.
`timescale 1ns/100ps
module bcu_pin_model (
  input  wire logic hclk,
  input  wire logic level_req,
  output logic      irq_pin
);
  initial irq_pin = 1'b1;
  always @(posedge hclk) irq_pin <= level_req;
endmodule // bcu_pin_model

// [tb/bcu_core_assertions.sv]
// Checker beside bcu_core: bus timing and flag effects seen when CORE is read back.
// Assumes one master with hready tied to hreadyout and word-wide writes.
`timescale 1ns/100ps
module bcu_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq_pin
);
  logic       dp, dw, ran, take, wdone, rcore;
  logic [7:0] da, op, fl, ac;
  assign take  = hready && hsel && htrans[1];
  assign wdone = dp && dw && hreadyout;
  assign rcore = dp && !dw && hreadyout && da == 8'h08 && ran;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dp, dw, ran} <= 3'b000;
      {da, op, fl, ac} <= 32'h0000_0000;
    end else begin
      if (hready) begin
        {dp, dw, da} <= {take, hwrite, haddr[7:0]};
      end
      if (wdone && da == 8'h00)
        op <= hwdata[7:0];
      if (wdone && da == 8'h08)
        {fl, ac} <= {hwdata[31:24], hwdata[7:0]};
      if (wdone && da <= 8'h0C)
        ran <= 1'b0;
      else if (wdone && da == 8'h10 && hwdata[0])
        ran <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave gave an error response");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase did not take exactly one wait cycle");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase was stretched");
  branch_flags_a: assert property (
    rcore && (op[7:4] == 4'h2 || op == 8'h91 || op == 8'h93) |-> hrdata[31:24] == fl)
    else $error("a branch changed the flags");
  carry_clear_a: assert property (
    rcore && op == 8'h98 |-> hrdata[31:24] == (fl & 8'hFE))
    else $error("carry clear gave wrong flags");
  mask_clear_a: assert property (
    rcore && op == 8'h9A |-> hrdata[31:24] == (fl & 8'hF7))
    else $error("mask clear gave wrong flags");
  high_clear_a: assert property (
    rcore && op == 8'h8C |-> hrdata[31:16] == {(fl & 8'h7B) | 8'h02, 8'h00})
    else $error("index high clear gave wrong result");
  invert_acc_a: assert property (
    rcore && op == 8'h43 |-> hrdata[7:0] == ~ac && hrdata[31] == 1'b0 && hrdata[24] == 1'b1)
    else $error("accumulator complement gave wrong result");
  shift_right_a: assert property (
    rcore && op == 8'h44 |-> hrdata[7:0] == {1'b0, ac[7:1]} && hrdata[24] == ac[0]
    && hrdata[26] == 1'b0)
    else $error("accumulator shift gave wrong result");
endmodule // bcu_checker

bind bcu_core bcu_checker u_bcu_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pin(irq_pin));

// [tb/cpu_branch_compare_load_ops_test.sv]
// Self-checking bench of bcu_core over AHB-Lite with the pin model beside it.
// Assumes hready is tied to hreadyout and single word transfers.
`timescale 1ns/100ps
module cpu_branch_compare_load_ops_test;
  typedef struct packed {logic on; logic [31:0] m; logic [31:0] e;} bcu_note_s;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lvl = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, seed = 32'hA4D2, rv, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, irq_pin, tk, mdp = 1'b0, mwr = 1'b0;
  logic [7:0]  o, f, f2, off, mm;
  logic [7:0]  bops [10] = '{8'h28, 8'h29, 8'h22, 8'h23, 8'h2C, 8'h2D, 8'h91, 8'h93, 8'h2E,
                             8'h2F};
  logic [15:0] ln, pc;
  int          errors = 0, samples_checked = 0;
  bcu_note_s   notes[$], nt;
  wire         hready = hreadyout;
  always #25 hclk = ~hclk;
  bcu_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_pin(irq_pin));
  bcu_pin_model u_pin (.hclk(hclk), .level_req(lvl), .irq_pin(irq_pin));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic conclude();
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      conclude();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    wait_rdy(n);
    {hsel, htrans, hwdata} <= {3'b000, d};
    wait_rdy(n);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic ex(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    notes.push_back('{1'b1, m, e});
    xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic run(input logic [23:0] ins, input logic [15:0] m, input logic [31:0] core,
                     input logic [31:0] pcsp);
    logic [31:0] r;
    int k;
    wr(8'h00, {8'h00, ins});
    wr(8'h04, {16'h0000, m});
    wr(8'h08, core);
    wr(8'h0C, pcsp);
    wr(8'h10, 32'h0000_0001);
    k = 0;
    do begin
      notes.push_back('{1'b0, 32'h0, 32'h0});
      xfer(1'b0, 8'h14, 32'h0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 20);
    if (k >= 20) begin
      errors++;
      conclude();
    end
  endtask
  task automatic one(input logic [23:0] ins, input logic [15:0] m, input logic [31:0] core,
                     input logic [31:0] xcore, input logic [15:0] xpc);
    run(ins, m, core, 32'h00FF_0100);
    ex(8'h08, 32'hFFFF_FFFF, xcore);
    ex(8'h0C, 32'hFFFF_FFFF, {16'h00FF, xpc});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (mdp && !mwr && hready && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.on)
        check(hrdata & nt.m, nt.e);
    end
    if (hready) begin
      mdp <= hsel && htrans[1];
      mwr <= hwrite;
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ex(8'h08, 32'hFFFF_FFFF, 32'h0800_0000);
    ex(8'h0C, 32'hFFFF_FFFF, 32'h00FF_0000);
    ex(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int k = 0; k < 36; k++) begin
      rv = rnd();
      {off, mm, f} = rv[23:0];
      pc = rv[31:16];
      f2 = f;
      lvl <= (k >= 10);
      if (k < 20) begin
        o = bops[k % 10];
        case (o)
          8'h28: tk = !f[4];
          8'h29: tk = f[4];
          8'h22: tk = !(f[0] | f[1]);
          8'h23: tk = f[0] | f[1];
          8'h2C: tk = !f[3];
          8'h2D: tk = f[3];
          8'h91: tk = f[2] ^ f[7];
          8'h93: tk = f[1] | (f[2] ^ f[7]);
          8'h2E: tk = (k < 10);
          default: tk = (k >= 10);
        endcase
        run({8'h00, off, o}, 16'h0, {f, 24'h123456}, {16'h00FF, pc});
        ln = 16'd2;
      end else begin
        o = 8'(k - 20);
        tk = mm[o[3:1]] ^ o[0];
        f2[0] = mm[o[3:1]];
        run({off, 8'h40, o}, {8'h00, mm}, {f, 24'h123456}, {16'h00FF, pc});
        ln = 16'd3;
      end
      ex(8'h14, 32'h7, {29'h0, tk, 2'b00} >> 1);
      ex(8'h08, 32'hFFFF_FFFF, {f2, 24'h123456});
      ex(8'h0C, 32'hFFFF_FFFF, {16'h00FF, pc + ln + (tk ? {{8{off[7]}}, off} : 16'h0)});
    end
    for (int n = 0; n < 8; n++) begin
      rv = rnd();
      run({8'h00, 8'h40, 8'h10 + 8'(2 * n)}, {8'h00, rv[7:0]}, 32'h0512_3456, 32'h00FF_0100);
      ex(8'h14, 32'h00FF_000C, {8'h00, rv[7:0] | (8'h01 << n), 16'h0008});
      ex(8'h18, 32'hFFFF_0000, 32'h0040_0000);
      ex(8'h08, 32'hFF00_0000, 32'h0500_0000);
    end
    run({8'h00, 8'hF0, 8'hAD}, 16'h0, 32'h0, 32'h00F0_1234);
    ex(8'h0C, 32'hFFFF_FFFF, 32'h00EE_1226);
    ex(8'h1C, 32'h0000_FFFF, 32'h0000_1236);
    ex(8'h18, 32'hFFFF_0000, 32'h00F0_0000);
    ex(8'h14, 32'h0000_0010, 32'h0000_0010);
    run({8'h00, 8'h80, 8'hBD}, 16'h0, 32'h0, 32'h00FF_2000);
    ex(8'h0C, 32'hFFFF_FFFF, 32'h00FD_0080);
    ex(8'h1C, 32'h0000_FFFF, 32'h0000_2002);
    one(24'h055641, 16'h0, 32'h0712_3456, 32'h0712_3456, 16'h0108);
    one(24'h054031, 16'h56, 32'h0712_3456, 32'h0712_3456, 16'h0108);
    one(24'h053551, 16'h0, 32'h0712_3456, 32'h0712_3456, 16'h0103);
    one(24'h000471, 16'h56, 32'h0012_FF56, 32'h0013_0056, 16'h0106);
    one(24'h000098, 16'h0, 32'h0F12_3456, 32'h0E12_3456, 16'h0101);
    one(24'h00009A, 16'h0, 32'h8B12_3456, 32'h8312_3456, 16'h0101);
    one(24'h00008C, 16'h0, 32'h8412_3456, 32'h0200_3456, 16'h0101);
    one(24'h00004F, 16'h0, 32'h8512_3456, 32'h0312_3400, 16'h0101);
    one(24'h0060A1, 16'h0, 32'h0812_3456, 32'h0D12_3456, 16'h0102);
    one(24'h0001A1, 16'h0, 32'h0F12_3480, 32'h8812_3480, 16'h0102);
    one(24'h000043, 16'h0, 32'h8012_3456, 32'h0512_34A9, 16'h0101);
    one(24'h351265, 16'h0, 32'h0012_3456, 32'h0512_3456, 16'h0103);
    one(24'h004075, 16'h3412, 32'h0012_3456, 32'h0212_3456, 16'h0102);
    one(24'h000072, 16'h0, 32'h0012_349A, 32'h0312_3400, 16'h0101);
    one(24'h000072, 16'h0, 32'h1012_3415, 32'h1012_341B, 16'h0101);
    one(24'h00105B, 16'h0, 32'h0F12_0156, 32'h0F12_0056, 16'h0102);
    one(24'h00105B, 16'h0, 32'h0012_0056, 32'h0012_FF56, 16'h0112);
    one(24'h00FE4B, 16'h0, 32'h0012_3402, 32'h0012_3401, 16'h0100);
    one(24'h000052, 16'h0, 32'h0B01_1064, 32'h0804_1016, 16'h0101);
    one(24'h000052, 16'h0, 32'h0010_0100, 32'h0110_0100, 16'h0101);
    one(24'h348245, 16'h0, 32'h8000_0000, 32'h0482_3400, 16'h0103);
    one(24'h004055, 16'h0, 32'h0012_3456, 32'h0200_0056, 16'h0102);
    one(24'h400032, 16'h2211, 32'h0612_3456, 32'h0011_2256, 16'h0103);
    one(24'h000044, 16'h0, 32'h0412_3401, 32'h8312_3400, 16'h0101);
    one(24'h00407E, 16'h80, 32'h8212_3456, 32'h0412_3556, 16'h0102);
    ex(8'h14, 32'h00FF_0008, 32'h0080_0008);
    ex(8'h18, 32'hFFFF_0000, 32'h0040_0000);
    one(24'h000013, 16'h0, 32'h0512_3456, 32'h0512_3456, 16'h0100);
    ex(8'h14, 32'h0000_001F, 32'h0000_0004);
    conclude();
  end
endmodule // cpu_branch_compare_load_ops_test
